/* File: rps_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz clock
// Notes:   Included by the sequencer files
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RPS_OFF_UP_ORDER     8'h09
`define RPS_OFF_UP_DELAYS    8'h0A
`define RPS_OFF_DOWN_ORDER   8'h0B
`define RPS_OFF_DOWN_DELAYS  8'h0C
`define RPS_OFF_POWER_GOOD   8'h0F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RPS_RST_UP_ORDER     8'hE4
`define RPS_RST_UP_DELAYS    8'h55
`define RPS_RST_DOWN_ORDER   8'h1E
`define RPS_RST_DOWN_DELAYS  8'hE0

// ----------------------------------------
// Field positions (rail index r uses bits 2r+1:2r)
// ----------------------------------------
`define RPS_RAIL_SOURCE_NEG  0
`define RPS_RAIL_GATE_LOW    1
`define RPS_RAIL_SOURCE_POS  2
`define RPS_RAIL_GATE_HIGH   3
`define RPS_DN_FACTOR_BIT    0
`define RPS_DN_FIRST_BIT     1
`define RPS_PG_GATE_HIGH     6
`define RPS_PG_NEG_BOOST     5
`define RPS_PG_SOURCE_POS    4
`define RPS_PG_GATE_LOW      3
`define RPS_PG_SOURCE_NEG    1

// ----------------------------------------
// Timing
// ----------------------------------------
`define RPS_CLK_MHZ          100
`define RPS_MS_NS            1000000
`define RPS_CLK_NS           10
`define RPS_MS_CYCLES        (`RPS_MS_NS / `RPS_CLK_NS)
`define RPS_UP_STEP_MS       3
`define RPS_DN_STEP_MS       6
`define RPS_DN_FIRST_MS      3
`define RPS_DN_FACTOR        16

`endif

/* File: rps_pkg.sv */
// Purpose: Types of the rail power sequencer
// Assumes: Nothing
// Notes:   States only
package rps_pkg;

    typedef enum logic [1:0] {
        RPS_OFF,
        RPS_UP,
        RPS_ON,
        RPS_DOWN
    } rps_state_t;

endpackage : rps_pkg

/* File: rps_ms_timer.sv */
// Purpose: Millisecond delay counter
// Assumes: Load pulse starts a new count
// Notes:   Done is a one-cycle pulse when the count runs out
`timescale 1ns/1ns
`include "rps_defs.svh"

module rps_ms_timer #(
    parameter int MS_CYCLES = `RPS_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Control
    input  wire logic        i_load,
    input  wire logic [9:0]  i_ms,
    input  wire logic        i_abort,
    // Status
    output logic             o_done
);

    logic [9:0]  ms_left;
    logic [19:0] tick;
    logic        running;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn || i_abort) begin
            ms_left <= 10'h000;
            tick    <= 20'h00000;
            running <= 1'b0;
            o_done  <= 1'b0;
        end else if (i_load) begin
            ms_left <= i_ms;
            tick    <= 20'(MS_CYCLES - 1);
            running <= 1'b1;
            o_done  <= 1'b0;
        end else if (running) begin
            o_done <= 1'b0;
            if (tick != 20'h00000) begin
                tick <= tick - 20'h00001;
            end else if (ms_left <= 10'h001) begin
                running <= 1'b0;
                o_done  <= 1'b1;
            end else begin
                ms_left <= ms_left - 10'h001;
                tick    <= 20'(MS_CYCLES - 1);
            end
        end else begin
            o_done <= 1'b0;
        end
    end

endmodule : rps_ms_timer

/* File: rps_sequencer.sv */
// Purpose: Four-strobe power sequencer for four display supply rails
// Assumes: Registers reached by a plain byte port; pins synchronous
// Notes:   Rail index 0 source neg, 1 gate low, 2 source pos, 3 gate high
`timescale 1ns/1ns
`include "rps_defs.svh"

module rps_sequencer #(
    parameter int MS_CYCLES = `RPS_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Register port
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic [7:0]       o_reg_rdata,
    // Sequencing inputs
    input  wire logic        i_wake_request,
    input  wire logic        i_neg_boost_in_reg,
    input  wire logic        i_gate_high_good,
    input  wire logic        i_source_pos_good,
    input  wire logic        i_gate_low_good,
    input  wire logic        i_source_neg_good,
    // Rail enables
    output logic [3:0]       o_rail_enable,
    output logic             o_sequence_busy,
    // Open-drain power good pin
    output logic             o_power_good_pin_out,
    output logic             o_power_good_pin_oe
);

    logic [7:0]          power_up_order;
    logic [7:0]          power_up_delays;
    logic [7:0]          power_down_order;
    logic [7:0]          power_down_delays;
    rps_pkg::rps_state_t state;
    logic [1:0]          step;
    logic                waiting;
    logic                wake_d;
    logic                load;
    logic [9:0]          load_ms;
    logic                abort;
    logic                done;
    logic                neg_boost_power_good;
    logic                all_good;
    logic [7:0]          pg_status;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] field(input logic [7:0] r,
                                         input logic [1:0] idx);
        field = r[2*idx +: 2];
    endfunction : field

    // Gap g of 1..3 sits in bits 2g+1:2g of the delay register
    function automatic logic [9:0] up_ms(input logic [1:0] code);
        up_ms = 10'(`RPS_UP_STEP_MS * (int'(code) + 1));
    endfunction : up_ms

    function automatic logic [9:0] down_ms(input logic [1:0] code,
                                           input logic       fac);
        logic [9:0] base;
        base = 10'(`RPS_DN_STEP_MS << code);
        down_ms = fac ? 10'(base * `RPS_DN_FACTOR) : base;
    endfunction : down_ms

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            power_up_order    <= `RPS_RST_UP_ORDER;
            power_up_delays   <= `RPS_RST_UP_DELAYS;
            power_down_order  <= `RPS_RST_DOWN_ORDER;
            power_down_delays <= `RPS_RST_DOWN_DELAYS;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `RPS_OFF_UP_ORDER:    power_up_order    <= i_reg_wdata;
                `RPS_OFF_UP_DELAYS:   power_up_delays   <= i_reg_wdata;
                `RPS_OFF_DOWN_ORDER:  power_down_order  <= i_reg_wdata;
                `RPS_OFF_DOWN_DELAYS: power_down_delays <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    assign neg_boost_power_good = i_neg_boost_in_reg;
    assign all_good = i_gate_high_good && i_source_pos_good &&
                      i_gate_low_good && i_source_neg_good;

    always_comb begin
        pg_status = 8'h00;
        pg_status[`RPS_PG_GATE_HIGH]  = i_gate_high_good;
        pg_status[`RPS_PG_NEG_BOOST]  = neg_boost_power_good;
        pg_status[`RPS_PG_SOURCE_POS] = i_source_pos_good;
        pg_status[`RPS_PG_GATE_LOW]   = i_gate_low_good;
        pg_status[`RPS_PG_SOURCE_NEG] = i_source_neg_good;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                `RPS_OFF_UP_ORDER:    o_reg_rdata <= power_up_order;
                `RPS_OFF_UP_DELAYS:   o_reg_rdata <= power_up_delays;
                `RPS_OFF_DOWN_ORDER:  o_reg_rdata <= power_down_order;
                `RPS_OFF_DOWN_DELAYS: o_reg_rdata <= power_down_delays;
                `RPS_OFF_POWER_GOOD:  o_reg_rdata <= pg_status;
                default:              o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Open drain: pull low unless every rail is good
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_power_good_pin_oe <= 1'b1;
        end else begin
            o_power_good_pin_oe <= !all_good;
        end
    end
    assign o_power_good_pin_out = 1'b0;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wake_d <= 1'b0;
        end else begin
            wake_d <= i_wake_request;
        end
    end

    always_comb begin
        load    = 1'b0;
        load_ms = 10'h000;
        abort   = 1'b0;
        case (state)
            rps_pkg::RPS_OFF: begin
                if (waiting && done) begin
                    // First gap starts with the first strobe
                    load    = 1'b1;
                    load_ms = up_ms(field(power_up_delays, 2'd1));
                end else if (i_wake_request && neg_boost_power_good &&
                             !waiting) begin
                    load    = 1'b1;
                    load_ms = up_ms(field(power_up_delays, 2'd0));
                end
            end
            rps_pkg::RPS_UP: begin
                if (!i_wake_request) begin
                    abort = 1'b1;
                end else if (done && step < 2'd2) begin
                    load    = 1'b1;
                    load_ms = up_ms(field(power_up_delays, step + 2'd2));
                end
            end
            rps_pkg::RPS_ON: begin
                if (!i_wake_request && wake_d) begin
                    load    = 1'b1;
                    load_ms = power_down_delays[`RPS_DN_FIRST_BIT] ?
                              10'(2 * `RPS_DN_FIRST_MS) :
                              10'(`RPS_DN_FIRST_MS);
                end
            end
            rps_pkg::RPS_DOWN: begin
                if (done && step != 2'd3) begin
                    load    = 1'b1;
                    load_ms = down_ms(field(power_down_delays, step + 2'd1),
                              power_down_delays[`RPS_DN_FACTOR_BIT]);
                end
            end
            default: abort = 1'b1;
        endcase
    end

    // Up and down both run strobes one to four in order
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state         <= rps_pkg::RPS_OFF;
            step          <= 2'd0;
            waiting       <= 1'b0;
            o_rail_enable <= 4'h0;
        end else begin
            case (state)
                rps_pkg::RPS_OFF: begin
                    if (waiting && done) begin
                        waiting <= 1'b0;
                        state   <= rps_pkg::RPS_UP;
                        step    <= 2'd0;
                        for (int r = 0; r < 4; r++) begin
                            if (field(power_up_order, 2'(r)) == 2'd0)
                                o_rail_enable[r] <= 1'b1;
                        end
                    end else if (load) begin
                        waiting <= 1'b1;
                    end else if (!i_wake_request) begin
                        waiting <= 1'b0;
                    end
                end
                rps_pkg::RPS_UP: begin
                    if (!i_wake_request) begin
                        // Aborted start parks in the on state; rails already strobed stay on
                        state <= rps_pkg::RPS_ON;
                    end else if (done) begin
                        // Strobe four ends the climb; no gap after it
                        step <= step + 2'd1;
                        if (step == 2'd2) begin
                            state <= rps_pkg::RPS_ON;
                        end
                        for (int r = 0; r < 4; r++) begin
                            if (field(power_up_order, 2'(r)) ==
                                step + 2'd1)
                                o_rail_enable[r] <= 1'b1;
                        end
                    end
                end
                rps_pkg::RPS_ON: begin
                    if (load) begin
                        state <= rps_pkg::RPS_DOWN;
                        step  <= 2'd0;
                    end
                end
                rps_pkg::RPS_DOWN: begin
                    if (done) begin
                        step <= step + 2'd1;
                        if (step == 2'd3) begin
                            state <= rps_pkg::RPS_OFF;
                        end
                        for (int r = 0; r < 4; r++) begin
                            if (field(power_down_order, 2'(r)) == step)
                                o_rail_enable[r] <= 1'b0;
                        end
                    end
                end
                default: state <= rps_pkg::RPS_OFF;
            endcase
        end
    end

    assign o_sequence_busy = (state == rps_pkg::RPS_UP) ||
                             (state == rps_pkg::RPS_DOWN) || waiting;

    rps_ms_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_load  (load),
        .i_ms    (load_ms),
        .i_abort (abort),
        .o_done  (done)
    );

endmodule : rps_sequencer

/* File: rps_seq_monitor.sv */
// Purpose: Port checker of the rail sequencer
// Assumes: Shadow delay copies follow register writes
// Notes:   Counter restarts on any rail, wake or boost change
`timescale 1ns/1ns
`include "rps_defs.svh"
module rps_seq_monitor #(
    parameter int MS_CYCLES = 10
) (
    // Clock and reset
    input wire logic       i_clk,
    input wire logic       i_rstn,
    // Register port
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    // Pins
    input wire logic       i_wake_request,
    input wire logic       i_neg_boost_in_reg,
    input wire logic       i_gate_high_good,
    input wire logic       i_source_pos_good,
    input wire logic       i_gate_low_good,
    input wire logic       i_source_neg_good,
    input wire logic [3:0] o_rail_enable,
    input wire logic       o_sequence_busy,
    input wire logic       o_power_good_pin_out,
    input wire logic       o_power_good_pin_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [7:0] up_dly;
    logic [7:0] dn_dly;
    int         cnt;
    int         up_lo;
    int         dn_lo;
    logic       all_good;
    assign all_good = i_gate_high_good & i_source_pos_good
                    & i_gate_low_good & i_source_neg_good;
    assign up_lo = 3 * (int'(up_dly[1:0]) + 1) * MS_CYCLES;
    assign dn_lo = (dn_dly[1] ? 6 : 3) * MS_CYCLES;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            up_dly <= `RPS_RST_UP_DELAYS;
            dn_dly <= `RPS_RST_DOWN_DELAYS;
        end else if (i_reg_wr && i_reg_addr == `RPS_OFF_UP_DELAYS) begin
            up_dly <= i_reg_wdata;
        end else if (i_reg_wr && i_reg_addr == `RPS_OFF_DOWN_DELAYS) begin
            dn_dly <= i_reg_wdata;
        end
    end
    // Cycles since the last event that may open a delay
    always_ff @(posedge i_clk) begin
        if (!i_rstn || $changed(o_rail_enable) || $changed(i_wake_request)
            || $changed(i_neg_boost_in_reg)) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    sequence s_first_on;
        $past(o_rail_enable) == 4'h0 && o_rail_enable != 4'h0;
    endsequence
    sequence s_first_off;
        $past(o_rail_enable) == 4'hF && o_rail_enable != 4'hF;
    endsequence
    a_first_up_time: assert property (s_first_on |->
        cnt >= up_lo && cnt <= up_lo + 8) else $error("first up strobe time");
    a_first_down_time: assert property (s_first_off |->
        cnt >= dn_lo && cnt <= dn_lo + 8) else $error("first down strobe time");
    a_pin_low_only: assert property (o_power_good_pin_out == 1'b0)
        else $error("power good pin driven high");
    a_pin_needs_good: assert property (!o_power_good_pin_oe |->
        $past(all_good)) else $error("power good pin released early");
    a_pin_releases: assert property (all_good [*3] |=>
        !o_power_good_pin_oe) else $error("power good pin held low");
    a_boost_status: assert property ((i_reg_addr == 8'h0F
        && $stable(i_neg_boost_in_reg)) [*3] |->
        o_reg_rdata[5] == i_neg_boost_in_reg) else $error("boost status bit");
    a_rails_only_rise: assert property (i_wake_request [*2] |->
        (~o_rail_enable & $past(o_rail_enable)) == 4'h0)
        else $error("rail dropped while awake");
    a_rails_only_fall: assert property (!i_wake_request [*2] |->
        (o_rail_enable & ~$past(o_rail_enable)) == 4'h0)
        else $error("rail raised while asleep");
    a_change_in_busy: assert property ($changed(o_rail_enable) |->
        $past(o_sequence_busy)) else $error("rail change outside sequence");
endmodule : rps_seq_monitor
bind rps_sequencer rps_seq_monitor #(.MS_CYCLES(MS_CYCLES)) i_rps_seq_monitor (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_wake_request(i_wake_request),
    .i_neg_boost_in_reg(i_neg_boost_in_reg),
    .i_gate_high_good(i_gate_high_good), .i_source_pos_good(i_source_pos_good),
    .i_gate_low_good(i_gate_low_good), .i_source_neg_good(i_source_neg_good),
    .o_rail_enable(o_rail_enable), .o_sequence_busy(o_sequence_busy),
    .o_power_good_pin_out(o_power_good_pin_out),
    .o_power_good_pin_oe(o_power_good_pin_oe));

/* File: rps_rail_model.sv */
// Purpose: Converters and pumps that answer the enables
// Assumes: A good rises LAG clocks after its enable
// Notes:   Good drops one clock after its enable falls, as a discharged rail would
`timescale 1ns/1ns
module rps_rail_model #(
    parameter int LAG = 3
) (
    // Clock
    input  wire logic       i_clk,
    // Enables, bit 4 the negative boost
    input  wire logic [4:0] i_on,
    // Regulation flags
    output logic      [4:0] o_good
);
    int cnt [5];
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 5; i++) begin
            if (!i_on[i]) begin
                cnt[i] <= 0;
            end else if (cnt[i] < LAG) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 5; i++) o_good[i] = (cnt[i] == LAG);
    end
endmodule : rps_rail_model

/* File: rps_sequencer_tb_top.sv */
// Purpose: Register and sequencing tests of the rail sequencer
// Assumes: Ten clocks stand for one millisecond
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ns
`include "rps_defs.svh"
module rps_sequencer_tb_top;
    localparam int MS = 10;
    localparam logic [7:0] OFS [4] = '{8'h09, 8'h0A, 8'h0B, 8'h0C};
    localparam logic [7:0] RST [4] = '{8'hE4, 8'h55, 8'h1E, 8'hE0};
    logic       i_clk = 1'b0;
    logic       i_rstn;
    logic       i_reg_wr;
    logic [7:0] i_reg_addr;
    logic [7:0] i_reg_wdata;
    logic [7:0] o_reg_rdata;
    logic       i_wake_request;
    logic       boost_on;
    logic       boost_good;
    logic [3:0] good;
    logic [3:0] o_rail_enable;
    logic       busy;
    logic       pg_oe;
    int         cyc = 0;
    int         n_mismatch = 0;
    int         tests_run = 0;
    rps_sequencer #(.MS_CYCLES(MS)) i_rps_sequencer (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_wake_request(i_wake_request),
        .i_neg_boost_in_reg(boost_good), .i_gate_high_good(good[3]),
        .i_source_pos_good(good[2]), .i_gate_low_good(good[1]),
        .i_source_neg_good(good[0]), .o_rail_enable(o_rail_enable),
        .o_sequence_busy(busy), .o_power_good_pin_out(),
        .o_power_good_pin_oe(pg_oe));
    rps_rail_model i_rps_rail_model (.i_clk(i_clk),
        .i_on({boost_on, o_rail_enable}), .o_good({boost_good, good}));
    always #5 i_clk = ~i_clk;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    // Hang guard, well above the longest run
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic at(input int c);
        while (cyc < c) @(negedge i_clk);
    endtask : at
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_wr    = 1'b1;
        i_reg_addr  = a;
        i_reg_wdata = d;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
        // Strobe stays low for one edge between writes
        @(negedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_reg_addr = a;
        @(negedge i_clk);
        chk(o_reg_rdata, e);
    endtask : rd
    task automatic cfg(input logic [7:0] v [4]);
        for (int i = 0; i < 4; i++) wr(OFS[i], v[i]);
        for (int i = 0; i < 4; i++) rd(OFS[i], v[i]);
    endtask : cfg
    function automatic logic [3:0] exp_en(input bit up, input logic [7:0] o,
                                          input int k);
        logic [3:0] e;
        for (int r = 0; r < 4; r++) begin
            e[r] = up ? (int'(o[2*r+:2]) <= k) : (int'(o[2*r+:2]) > k);
        end
        return e;
    endfunction : exp_en
    // One whole power-up or power-down, checked around each strobe
    task automatic run(input bit up, input logic [7:0] o, input logic [7:0] d);
        int t;
        int n;
        t = cyc;
        i_wake_request = up;
        for (int k = 0; k < 4; k++) begin
            if (up) n = 3 * (int'(d[2*k+:2]) + 1);
            else if (k == 0) n = d[1] ? 6 : 3;
            else n = (6 << d[2*k+:2]) * (d[0] ? 16 : 1);
            t = t + n * MS;
            at(t - 1);
            chk(8'(o_rail_enable), 8'(exp_en(up, o, k - 1)));
            at(t + 8);
            chk(8'(o_rail_enable), 8'(exp_en(up, o, k)));
        end
        at(t + 14);
        chk(8'(busy), 8'h00);
        chk(8'(pg_oe), 8'(!up));
        $display("test %s done", up ? "power up" : "power down");
    endtask : run
    initial begin
        i_rstn = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_wake_request = 1'b0;
        boost_on = 1'b0;
        repeat (3) @(negedge i_clk);
        i_rstn = 1'b1;
        for (int i = 0; i < 4; i++) rd(OFS[i], RST[i]);
        rd(8'h20, 8'h00);
        wr(8'h0F, 8'hFF);
        rd(8'h0F, 8'h00);
        boost_on = 1'b1;
        at(cyc + 10);
        rd(8'h0F, 8'h20);
        $display("test registers done");
        i_wake_request = 1'b1;
        at(cyc + 20);
        i_wake_request = 1'b0;
        at(cyc + 200);
        chk(8'(o_rail_enable), 8'h00);
        run(1'b1, 8'hE4, 8'h55);
        rd(8'h0F, 8'h7A);
        run(1'b0, 8'h1E, 8'hE0);
        cfg('{8'h1B, 8'hE4, 8'h00, 8'hE0});
        run(1'b1, 8'h1B, 8'hE4);
        run(1'b0, 8'h00, 8'hE0);
        cfg('{8'h00, 8'h03, 8'h1B, 8'h1B});
        run(1'b1, 8'h00, 8'h03);
        run(1'b0, 8'h1B, 8'h1B);
        wr(8'h09, 8'hE4);
        i_wake_request = 1'b1;
        at(cyc + 140);
        i_wake_request = 1'b0;
        at(cyc + 60);
        chk(8'({busy, o_rail_enable}), 8'h01);
        $display("test abort done");
        close_out();
    end
endmodule : rps_sequencer_tb_top
